// ===== bench/count_pulse_source.sv
// Counting pulse source that drives the count trigger pin.
`timescale 1ns/10ps
`default_nettype none
module count_pulse_source (
    // Clock, reset and request.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic slow,
    input wire logic [7:0] pulses,
    // Pin side.
    output logic trig,
    output logic busy
);
    logic [7:0] left;
    logic [2:0] ph;
    assign busy = left != 8'h00;
    // High two clocks, low two or six, so the pin synchroniser sees each pulse once.
    assign trig = busy && ph < 3'h2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 8'h00;
            ph <= 3'h0;
        end else if (start) begin
            left <= pulses;
            ph <= 3'h0;
        end else if (busy) begin
            ph <= ph + 3'h1;
            if (ph == {slow, 2'h3}) begin
                left <= left - 8'h01;
                ph <= 3'h0;
            end
        end
    end
endmodule : count_pulse_source
`default_nettype wire

// ===== bench/drive_output_indicator_counter_tb_top.sv
// Self-checking testbench of the drive output indicator block.
`timescale 1ns/10ps
`default_nettype none
module drive_output_indicator_counter_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    indicator_pkg::drive_meas_t meas = '0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [7:0] npulse = 8'h00;
    logic trig;
    logic busy;
    logic [2:0] mfo;
    logic [15:0] meter;
    logic fault;
    logic fan;
    logic irq;
    logic [31:0] rnd = 32'hE4D0E6A9;
    logic [31:0] q;
    logic [4:0] code [3];
    logic [4:0] tbl [4] = '{indicator_pkg::FN_ZERO_SPEED, indicator_pkg::FN_UNDER_CURRENT,
        indicator_pkg::FN_FEEDBACK, indicator_pkg::FN_LOW_BUS};
    int failures = 0;
    int total_checks = 0;
    always #2 clk = ~clk;
    drive_output_indicator_counter #(.FAN_DELAY(20), .OUTPUTS(3)) DUT (.CORE_CLK(clk),
        .ARST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .MEAS(meas), .COUNT_TRIGGER_INPUT(trig),
        .MULTI_FUNCTION_OUTPUTS(mfo), .ANALOG_METER_OUTPUT(meter),
        .PULSE_FREQUENCY_OUTPUT(), .COUNTER_FAULT_MESSAGE(fault), .FAN_ON(fan), .IRQ(irq));
    count_pulse_source src (.clk(clk), .rst_n(rst_n), .start(start), .slow(slow),
        .pulses(npulse), .trig(trig), .busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] fn_exp(input logic [4:0] c,
        input indicator_pkg::drive_meas_t m);
        case (c)
            indicator_pkg::FN_ZERO_SPEED: return {31'h0, m.out_freq == 16'h0000};
            indicator_pkg::FN_UNDER_CURRENT: return {31'h0, m.under_current};
            indicator_pkg::FN_FEEDBACK: return {31'h0, m.feedback_bad};
            default: return {31'h0, m.low_bus};
        endcase
    endfunction : fn_exp
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Waits are bounded so a stuck ready ends the run instead of hanging it.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            end_of_test();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("read", e, q);
    endtask : rd
    task automatic step(input logic [7:0] n, input logic [31:0] cnt, input logic [2:0] e);
        int k;
        npulse <= n;
        start <= 1'b1;
        slow <= rnd[0];
        rnd = lfsr(rnd);
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((busy || k < 2) && k < 3000);
        if (k >= 3000) begin
            failures++;
            end_of_test();
        end
        cyc(8);
        rd(indicator_pkg::REG_COUNT, cnt);
        chk("outputs", {29'h0, e}, {29'h0, mfo});
    endtask : step
    task automatic put(input logic [15:0] f, input logic s, input logic r, input logic [31:0] e,
        input logic [1:0] w);
        meas.out_freq <= f;
        meas.stop_cmd <= s;
        meas.running <= r;
        cyc(4);
        chk("level", e, (w == 2'h1) ? {31'h0, mfo[0]} : (w == 2'h2) ? {16'h0, meter} :
            (w == 2'h3) ? {31'h0, fan} : 32'h0);
    endtask : put
    initial begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(4);
        chk("fan", 32'h1, {31'h0, fan});
        rd(indicator_pkg::REG_COUNT, 32'h0);
        rd(8'h3C, 32'h0);
        bus(1'b1, indicator_pkg::REG_COUNT_SET, 32'h0000_FFFF);
        rd(indicator_pkg::REG_COUNT_SET, {16'h0, indicator_pkg::COUNT_MAX});
        bus(1'b1, indicator_pkg::REG_COUNT_SET, 32'h0005_000A);
        bus(1'b1, indicator_pkg::REG_OUTFN, {17'h0, indicator_pkg::FN_ZERO_SPEED,
            indicator_pkg::FN_PRELIM, indicator_pkg::FN_TERMINAL});
        bus(1'b1, indicator_pkg::REG_CTRL, 32'h0000_0008);
        step(8'h04, 32'h4, 3'h4);
        step(8'h01, 32'h5, 3'h6);
        step(8'h05, 32'hA, 3'h5);
        step(8'h03, 32'hA, 3'h5);
        chk("fault", 32'h0, {31'h0, fault});
        bus(1'b1, indicator_pkg::REG_COUNT_SET, 32'h0003_0006);
        bus(1'b1, indicator_pkg::REG_CTRL, 32'h0000_000C);
        step(8'h03, 32'h3, 3'h6);
        chk("fault", 32'h1, {31'h0, fault});
        rd(indicator_pkg::REG_IRQ_STAT, 32'h7);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, indicator_pkg::REG_IRQ_MASK, 32'h4);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, indicator_pkg::REG_CTRL, 32'h0000_0008);
        bus(1'b1, indicator_pkg::REG_IRQ_STAT, 32'h3F);
        rd(indicator_pkg::REG_IRQ_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        chk("fault", 32'h0, {31'h0, fault});
        // Random measurements against random output codes.
        for (int i = 0; i < 40; i++) begin
            for (int j = 0; j < 3; j++) begin
                code[j] = tbl[rnd[1:0]];
                rnd = lfsr(rnd);
            end
            bus(1'b1, indicator_pkg::REG_OUTFN, {17'h0, code[2], code[1], code[0]});
            meas.under_current <= rnd[3];
            meas.feedback_bad <= rnd[4];
            meas.low_bus <= rnd[5];
            put(rnd[2] ? 16'h0000 : {2'h0, rnd[29:16]}, 1'b0, 1'b0, 32'h0, 2'h0);
            rnd = lfsr(rnd);
            for (int j = 0; j < 3; j++) begin
                chk("indication", fn_exp(code[j], meas), {31'h0, mfo[j]});
            end
        end
        bus(1'b1, indicator_pkg::REG_OUTFN, {27'h0, indicator_pkg::FN_BRAKE});
        bus(1'b1, indicator_pkg::REG_BRAKE_SET, 32'h01F4_03E8);
        put(16'h0000, 1'b1, 1'b0, 32'h0, 2'h1);
        put(16'h03E7, 1'b0, 1'b0, 32'h0, 2'h1);
        put(16'h03E8, 1'b0, 1'b0, 32'h1, 2'h1);
        put(16'h01F5, 1'b1, 1'b0, 32'h1, 2'h1);
        put(16'h01F4, 1'b1, 1'b0, 32'h0, 2'h1);
        meas.max_freq <= indicator_pkg::FREQ_MAX;
        meas.rated_current <= 16'h0064;
        meas.out_current <= 16'h00FA;
        bus(1'b1, indicator_pkg::REG_METER, 32'h0001_6400);
        put(indicator_pkg::FREQ_MAX, 1'b0, 1'b0, 32'hFFFF, 2'h2);
        bus(1'b1, indicator_pkg::REG_METER, 32'h0001_6401);
        put(16'h0000, 1'b0, 1'b0, 32'hFFFF, 2'h2);
        bus(1'b1, indicator_pkg::REG_CTRL, {30'h0, indicator_pkg::FAN_RUN_ONLY});
        put(16'h0000, 1'b0, 1'b0, 32'h0, 2'h3);
        put(16'h0000, 1'b0, 1'b1, 32'h1, 2'h3);
        bus(1'b1, indicator_pkg::REG_CTRL, {30'h0, indicator_pkg::FAN_DELAYED});
        put(16'h0000, 1'b0, 1'b0, 32'h1, 2'h3);
        cyc(8);
        chk("fan", 32'h1, {31'h0, fan});
        cyc(20);
        chk("fan", 32'h0, {31'h0, fan});
        end_of_test();
    end
endmodule : drive_output_indicator_counter_tb_top
`default_nettype wire

// ===== bench/indicator_checker.sv
// Checker of output indications, bound to the indicator block.
`timescale 1ns/10ps
`default_nettype none
module indicator_checker #(
    parameter int OUTPUTS = 3
) (
    // Clock, reset and bus.
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    // Measurements and outputs.
    input wire indicator_pkg::drive_meas_t MEAS,
    input wire logic [OUTPUTS-1:0] MULTI_FUNCTION_OUTPUTS,
    input wire logic COUNTER_FAULT_MESSAGE,
    input wire logic FAN_ON
);
    // Settings are snooped from bus writes, since only the ports are visible here.
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [14:0] outfn;
    logic [2:0] ctrl;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            outfn <= 15'h0000;
            ctrl <= 3'h0;
        end else if (HREADY) begin
            wr_pend <= HSEL && HTRANS[1] && HWRITE;
            wr_addr <= HADDR[7:0];
            if (wr_pend && wr_addr == indicator_pkg::REG_OUTFN) begin
                outfn <= HWDATA[14:0];
            end
            if (wr_pend && wr_addr == indicator_pkg::REG_CTRL) begin
                ctrl <= HWDATA[2:0];
            end
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    chk_zero_speed: assert property (outfn[14:10] == indicator_pkg::FN_ZERO_SPEED
        |=> MULTI_FUNCTION_OUTPUTS[2] == ($past(MEAS.out_freq) == 16'h0000))
        else $error("zero speed output wrong");
    chk_under_cur: assert property (outfn[4:0] == indicator_pkg::FN_UNDER_CURRENT
        |=> MULTI_FUNCTION_OUTPUTS[0] == $past(MEAS.under_current))
        else $error("under current output wrong");
    chk_feedback_err: assert property (outfn[9:5] == indicator_pkg::FN_FEEDBACK
        |=> MULTI_FUNCTION_OUTPUTS[1] == $past(MEAS.feedback_bad))
        else $error("feedback output wrong");
    chk_low_bus: assert property (outfn[14:10] == indicator_pkg::FN_LOW_BUS
        |=> MULTI_FUNCTION_OUTPUTS[2] == $past(MEAS.low_bus))
        else $error("low bus output wrong");
    chk_prelim_drop: assert property ($past(outfn[9:0]) ==
        {indicator_pkg::FN_PRELIM, indicator_pkg::FN_TERMINAL}
        |-> !(MULTI_FUNCTION_OUTPUTS[0] && MULTI_FUNCTION_OUTPUTS[1]))
        else $error("preliminary and terminal outputs both high");
    chk_fan_always: assert property (ctrl[1:0] == indicator_pkg::FAN_ALWAYS |=> FAN_ON)
        else $error("fan off in always mode");
    chk_fan_run: assert property (ctrl[1:0] == indicator_pkg::FAN_RUN_ONLY
        |=> FAN_ON == $past(MEAS.running))
        else $error("fan not following run state");
    chk_fan_delayed: assert property (ctrl[1:0] == indicator_pkg::FAN_DELAYED
        && MEAS.running |=> FAN_ON)
        else $error("fan off while running");
    chk_fault_option: assert property ($rose(COUNTER_FAULT_MESSAGE) |-> $past(ctrl[2]))
        else $error("counter fault without fault option");
endmodule : indicator_checker
bind drive_output_indicator_counter indicator_checker #(.OUTPUTS(OUTPUTS)) u_chk (.CORE_CLK,
    .ARST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .MEAS,
    .MULTI_FUNCTION_OUTPUTS, .COUNTER_FAULT_MESSAGE, .FAN_ON);
`default_nettype wire

// ===== rtl/drive_output_indicator_counter.sv
// Counter, compare indications, meter, pulse output and fan control of the drive.
`timescale 1ns/10ps
`default_nettype none
module drive_output_indicator_counter #(
    parameter longint FAN_DELAY = indicator_pkg::FAN_DELAY_CYCLES,
    parameter int OUTPUTS = 3
) (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Drive measurements.
    input wire indicator_pkg::drive_meas_t MEAS,
    // Count trigger pin.
    input wire logic COUNT_TRIGGER_INPUT,
    // Outputs to relays, meters and fan.
    output logic [OUTPUTS-1:0] MULTI_FUNCTION_OUTPUTS,
    output logic [15:0] ANALOG_METER_OUTPUT,
    output logic PULSE_FREQUENCY_OUTPUT,
    output logic COUNTER_FAULT_MESSAGE,
    output logic FAN_ON,
    output logic IRQ
);
    logic rst_s1, rst_s2, rst_n;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    assign rst_n = rst_s2;

    // Bus address phase capture; the slave never stalls.
    logic ph_wr;
    logic [7:0] ph_addr;
    wire take = HSEL && HREADY && HTRANS[1];
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ph_wr <= 1'b0;
            ph_addr <= 8'h00;
        end else begin
            ph_wr <= take && HWRITE;
            ph_addr <= HADDR[7:0];
        end
    end

    // Software settings.
    logic [1:0] fan_mode;
    logic fault_opt;
    logic count_clear;
    logic [14:0] out_fn;
    logic [15:0] term_set, prelim_set, freq1_set, freq2_set, release_set, engage_set;
    logic [2:0] meter_src;
    logic [7:0] meter_gain;
    logic [4:0] pulse_mult;
    logic [indicator_pkg::IRQ_W-1:0] irq_stat, irq_mask;

    function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] lim);
        clip16 = (v > lim) ? lim : v;
    endfunction : clip16

    wire wr = ph_wr;
    wire wr_ctrl = wr && ph_addr == indicator_pkg::REG_CTRL;
    wire wr_cnt = wr && ph_addr == indicator_pkg::REG_COUNT_SET;
    wire wr_frq = wr && ph_addr == indicator_pkg::REG_FREQ_SET;
    wire wr_brk = wr && ph_addr == indicator_pkg::REG_BRAKE_SET;
    wire wr_met = wr && ph_addr == indicator_pkg::REG_METER;
    wire wr_ist = wr && ph_addr == indicator_pkg::REG_IRQ_STAT;
    wire [7:0] gain_in = HWDATA[15:8];
    wire [4:0] mult_in = HWDATA[20:16];

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fan_mode <= indicator_pkg::FAN_ALWAYS;
            fault_opt <= 1'b0;
            out_fn <= 15'h0000;
            term_set <= 16'h0000;
            prelim_set <= 16'h0000;
            freq1_set <= 16'h0000;
            freq2_set <= 16'h0000;
            release_set <= 16'h0000;
            engage_set <= 16'h0000;
            meter_src <= indicator_pkg::METER_FREQ;
            meter_gain <= indicator_pkg::GAIN_UNITY;
            pulse_mult <= indicator_pkg::PULSE_MULT_MIN;
            irq_mask <= '0;
        end else begin
            if (wr_ctrl) begin
                fan_mode <= (HWDATA[1:0] > indicator_pkg::FAN_RUN_ONLY) ? fan_mode : HWDATA[1:0];
                fault_opt <= HWDATA[2];
            end
            if (wr && ph_addr == indicator_pkg::REG_OUTFN) out_fn <= HWDATA[14:0];
            if (wr_cnt) begin
                term_set <= clip16(HWDATA[15:0], indicator_pkg::COUNT_MAX);
                prelim_set <= clip16(HWDATA[31:16], indicator_pkg::COUNT_MAX);
            end
            if (wr_frq) begin
                freq1_set <= clip16(HWDATA[15:0], indicator_pkg::FREQ_MAX);
                freq2_set <= clip16(HWDATA[31:16], indicator_pkg::FREQ_MAX);
            end
            if (wr_brk) begin
                release_set <= clip16(HWDATA[15:0], indicator_pkg::FREQ_MAX);
                engage_set <= clip16(HWDATA[31:16], indicator_pkg::FREQ_MAX);
            end
            if (wr_met) begin
                if (HWDATA[2:0] <= indicator_pkg::METER_PF) meter_src <= HWDATA[2:0];
                if (gain_in >= indicator_pkg::GAIN_MIN && gain_in <= indicator_pkg::GAIN_MAX)
                    meter_gain <= gain_in;
                if (mult_in >= indicator_pkg::PULSE_MULT_MIN &&
                    mult_in <= indicator_pkg::PULSE_MULT_MAX)
                    pulse_mult <= mult_in;
            end
            if (wr && ph_addr == indicator_pkg::REG_IRQ_MASK)
                irq_mask <= HWDATA[indicator_pkg::IRQ_W-1:0];
        end
    end
    assign count_clear = wr_ctrl && HWDATA[3];

    // Trigger synchroniser and rising edge.
    logic trg_s1, trg_s2, trg_s3;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            trg_s1 <= 1'b0;
            trg_s2 <= 1'b0;
            trg_s3 <= 1'b0;
        end else begin
            trg_s1 <= COUNT_TRIGGER_INPUT;
            trg_s2 <= trg_s1;
            trg_s3 <= trg_s2;
        end
    end
    wire trg_edge = trg_s2 && !trg_s3;

    // Event counter; holds at the terminal count until software clears it.
    logic [15:0] count;
    wire at_term = count >= term_set;
    wire at_prelim = count >= prelim_set;
    logic fault;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
            fault <= 1'b0;
        end else begin
            if (count_clear) count <= 16'h0000;
            else if (trg_edge && !at_term) count <= count + 16'h0001;
            if (count_clear) fault <= 1'b0;
            else if (fault_opt && at_prelim && !at_term) fault <= 1'b1;
        end
    end

    // Brake latch.
    logic brake;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) brake <= 1'b0;
        else if (MEAS.out_freq >= release_set && !MEAS.stop_cmd) brake <= 1'b1;
        else if (MEAS.stop_cmd && MEAS.out_freq <= engage_set) brake <= 1'b0;
    end

    // Indication per function code.
    wire zero_speed = MEAS.out_freq == 16'h0000;
    wire prelim_ind = at_prelim && !at_term;
    function automatic logic fn_level(input logic [4:0] code, input logic ts, input logic pr,
                                      input logic f1, input logic f2, input logic zs,
                                      input logic uc, input logic fb, input logic lb,
                                      input logic bk);
        case (code)
            indicator_pkg::FN_TERMINAL: fn_level = ts;
            indicator_pkg::FN_PRELIM: fn_level = pr;
            indicator_pkg::FN_FREQ1: fn_level = f1;
            indicator_pkg::FN_FREQ2: fn_level = f2;
            indicator_pkg::FN_ZERO_SPEED: fn_level = zs;
            indicator_pkg::FN_UNDER_CURRENT: fn_level = uc;
            indicator_pkg::FN_FEEDBACK: fn_level = fb;
            indicator_pkg::FN_LOW_BUS: fn_level = lb;
            indicator_pkg::FN_BRAKE: fn_level = bk;
            default: fn_level = 1'b0;
        endcase
    endfunction : fn_level

    wire f1_hit = MEAS.out_freq >= freq1_set;
    wire f2_hit = MEAS.out_freq >= freq2_set;
    genvar gi;
    generate
        for (gi = 0; gi < OUTPUTS; gi++) begin : g_out
            always_ff @(posedge CORE_CLK or negedge rst_n) begin
                if (!rst_n) MULTI_FUNCTION_OUTPUTS[gi] <= 1'b0;
                else MULTI_FUNCTION_OUTPUTS[gi] <= fn_level(out_fn[gi*5 +: 5], at_term,
                    prelim_ind, f1_hit, f2_hit, zero_speed, MEAS.under_current,
                    MEAS.feedback_bad, MEAS.low_bus, brake);
            end
        end
    endgenerate

    // Analog meter: selected quantity as a fraction of full scale, times gain.
    logic [15:0] m_val, m_full;
    always_comb begin
        m_val = MEAS.out_freq;
        m_full = MEAS.max_freq;
        case (meter_src)
            indicator_pkg::METER_FREQ: begin
                m_val = MEAS.out_freq;
                m_full = MEAS.max_freq;
            end
            indicator_pkg::METER_CURRENT: begin
                m_val = MEAS.out_current;
                m_full = 16'((32'(MEAS.rated_current) * 32'(indicator_pkg::CURRENT_FULL_PCT))
                             / 32'h64);
            end
            indicator_pkg::METER_VOLTAGE: begin
                m_val = MEAS.out_voltage;
                m_full = MEAS.max_voltage;
            end
            indicator_pkg::METER_COMMAND: m_val = MEAS.cmd_freq;
            indicator_pkg::METER_SPEED: m_val = MEAS.motor_speed;
            indicator_pkg::METER_PF: begin
                m_val = MEAS.power_factor;
                m_full = 16'hFFFF;
            end
            default: m_val = 16'h0000;
        endcase
    end
    // Divider is large but runs once per cycle; the meter is slow so timing is relaxed.
    wire [39:0] m_num = {m_val, 16'h0000} * 40'(meter_gain);
    wire [39:0] m_den = (m_full == 16'h0000) ? 40'h64 : 40'(m_full) * 40'h64;
    wire [39:0] m_q = m_num / m_den;
    wire [15:0] m_sat = (m_q > 40'hFFFF) ? 16'hFFFF : m_q[15:0];

    // Pulse output: phase accumulator at out_freq times the factor, in 0.01 Hz units.
    // Two toggles per output period, and the frequency is in hundredths of a hertz.
    localparam logic [39:0] ACC_WRAP = 40'(longint'(indicator_pkg::CLK_HZ) * 50);
    logic [39:0] acc;
    wire [39:0] step = 40'(MEAS.out_freq) * 40'(pulse_mult);
    wire [39:0] acc_sum = acc + step;

    // Fan delay counter.
    logic [39:0] fan_cnt;
    wire fan_next = (fan_mode == indicator_pkg::FAN_ALWAYS) ? 1'b1 :
                    (fan_mode == indicator_pkg::FAN_RUN_ONLY) ? MEAS.running :
                    (MEAS.running || fan_cnt != 40'h0);

    // Interrupts: set wins over a write-one clear.
    wire [indicator_pkg::IRQ_W-1:0] irq_ev = {MEAS.feedback_bad, MEAS.low_bus,
        MEAS.under_current, fault, prelim_ind, at_term};
    wire [indicator_pkg::IRQ_W-1:0] irq_clr = wr_ist ? HWDATA[indicator_pkg::IRQ_W-1:0] : '0;

    // Read data is registered at the address phase so it stands through the data phase.
    wire [7:0] ra = HADDR[7:0];
    wire [31:0] rd_mux =
        (ra == indicator_pkg::REG_CTRL) ? {29'h0, fault_opt, fan_mode} :
        (ra == indicator_pkg::REG_OUTFN) ? {17'h0, out_fn} :
        (ra == indicator_pkg::REG_COUNT_SET) ? {prelim_set, term_set} :
        (ra == indicator_pkg::REG_FREQ_SET) ? {freq2_set, freq1_set} :
        (ra == indicator_pkg::REG_BRAKE_SET) ? {engage_set, release_set} :
        (ra == indicator_pkg::REG_METER) ? {11'h0, pulse_mult, meter_gain, 5'h0, meter_src} :
        (ra == indicator_pkg::REG_COUNT) ? {16'h0, count} :
        (ra == indicator_pkg::REG_STATUS) ? {25'h0, FAN_ON, brake, zero_speed, fault,
                                             prelim_ind, at_term, PULSE_FREQUENCY_OUTPUT} :
        (ra == indicator_pkg::REG_IRQ_STAT) ? {26'h0, irq_stat} :
        (ra == indicator_pkg::REG_IRQ_MASK) ? {26'h0, irq_mask} :
        indicator_pkg::DECODE_ERR;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 40'h0;
            PULSE_FREQUENCY_OUTPUT <= 1'b0;
            fan_cnt <= 40'h0;
            FAN_ON <= 1'b1;
            ANALOG_METER_OUTPUT <= 16'h0000;
            COUNTER_FAULT_MESSAGE <= 1'b0;
            irq_stat <= '0;
            IRQ <= 1'b0;
            HRDATA <= 32'h0;
        end else begin
            if (acc_sum >= ACC_WRAP) begin
                acc <= acc_sum - ACC_WRAP;
                PULSE_FREQUENCY_OUTPUT <= ~PULSE_FREQUENCY_OUTPUT;
            end else begin
                acc <= acc_sum;
            end
            if (MEAS.running) fan_cnt <= 40'(FAN_DELAY);
            else if (fan_cnt != 40'h0) fan_cnt <= fan_cnt - 40'h1;
            FAN_ON <= fan_next;
            ANALOG_METER_OUTPUT <= m_sat;
            COUNTER_FAULT_MESSAGE <= fault;
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            IRQ <= |(((irq_stat & ~irq_clr) | irq_ev) & irq_mask);
            if (take && !HWRITE) HRDATA <= rd_mux;
        end
    end
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
endmodule : drive_output_indicator_counter
`default_nettype wire

// ===== rtl/indicator_pkg.sv
// Constants, codes and carrier types for the drive output indicator block.
package indicator_pkg;
    // Output function codes.
    localparam logic [4:0] FN_FREQ1 = 5'h09;
    localparam logic [4:0] FN_TERMINAL = 5'h0E;
    localparam logic [4:0] FN_PRELIM = 5'h0F;
    localparam logic [4:0] FN_ZERO_SPEED = 5'h11;
    localparam logic [4:0] FN_UNDER_CURRENT = 5'h12;
    localparam logic [4:0] FN_FREQ2 = 5'h16;
    localparam logic [4:0] FN_FEEDBACK = 5'h14;
    localparam logic [4:0] FN_LOW_BUS = 5'h15;
    localparam logic [4:0] FN_BRAKE = 5'h1D;
    // Setting limits.
    localparam logic [15:0] COUNT_MAX = 16'hFFDC;
    localparam logic [15:0] FREQ_MAX = 16'h9C40;
    localparam logic [4:0] PULSE_MULT_MIN = 5'h01;
    localparam logic [4:0] PULSE_MULT_MAX = 5'h14;
    localparam logic [7:0] GAIN_MIN = 8'h01;
    localparam logic [7:0] GAIN_MAX = 8'hC8;
    localparam logic [7:0] GAIN_UNITY = 8'h64;
    localparam logic [7:0] CURRENT_FULL_PCT = 8'hFA;
    // Meter sources.
    localparam logic [2:0] METER_FREQ = 3'h0;
    localparam logic [2:0] METER_CURRENT = 3'h1;
    localparam logic [2:0] METER_VOLTAGE = 3'h2;
    localparam logic [2:0] METER_COMMAND = 3'h3;
    localparam logic [2:0] METER_SPEED = 3'h4;
    localparam logic [2:0] METER_PF = 3'h5;
    // Fan modes.
    localparam logic [1:0] FAN_ALWAYS = 2'h0;
    localparam logic [1:0] FAN_DELAYED = 2'h1;
    localparam logic [1:0] FAN_RUN_ONLY = 2'h2;
    // Timing.
    localparam int CLK_HZ = 250000000;
    localparam int FAN_DELAY_S = 60;
    localparam longint FAN_DELAY_CYCLES = longint'(FAN_DELAY_S) * longint'(CLK_HZ);
    localparam int PULSE_ACC_W = 40;
    localparam logic [31:0] DECODE_ERR = 32'h0000_0000;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OUTFN = 8'h04;
    localparam logic [7:0] REG_COUNT_SET = 8'h08;
    localparam logic [7:0] REG_FREQ_SET = 8'h0C;
    localparam logic [7:0] REG_BRAKE_SET = 8'h10;
    localparam logic [7:0] REG_METER = 8'h14;
    localparam logic [7:0] REG_COUNT = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h24;
    // Interrupt status bit positions.
    localparam int IRQ_TERMINAL = 0;
    localparam int IRQ_PRELIM = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_UNDER = 3;
    localparam int IRQ_LOW_BUS = 4;
    localparam int IRQ_FEEDBACK = 5;
    localparam int IRQ_W = 6;

    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] cmd_freq;
        logic [15:0] motor_speed;
        logic [15:0] max_freq;
        logic [15:0] out_current;
        logic [15:0] rated_current;
        logic [15:0] out_voltage;
        logic [15:0] max_voltage;
        logic [15:0] power_factor;
        logic under_current;
        logic low_bus;
        logic feedback_bad;
        logic running;
        logic stop_cmd;
    } drive_meas_t;
endpackage : indicator_pkg
